// file: hdl/pgp_consts.svh
`ifndef PGP_CONSTS_SVH
`define PGP_CONSTS_SVH

// register indices; byte address is four times the index
`define PGP_IDX_PORT_E_DATA 6'h01
`define PGP_IDX_PORT_A_DIR 6'h02
`define PGP_IDX_PORT_E_DIR 6'h03
`define PGP_IDX_PORT_C_DATA 6'h04

// implemented bit fields
`define PGP_PORT_A_MSB 7
`define PGP_PORT_EC_MSB 1
`define PGP_SPI_MSB 3

// reset values
`define PGP_RST_PORT_A_DIR 8'h00
`define PGP_RST_PORT_E_DIR 2'h0
`define PGP_RST_PORT_E_DATA 2'h0
`define PGP_RST_PORT_C_DATA 2'h0

// pin ownership while the die link holds port c: pin 0 drives, pin 1 listens
`define PGP_DL_DIR 2'h1

`endif

// file: hdl/pgp_pkg.sv
package pgp_pkg;
	`include "pgp_consts.svh"

	typedef logic [`PGP_PORT_EC_MSB:0] pgp_pair_t;

	typedef struct packed {
		logic [`PGP_PORT_A_MSB:0] port_a_dir;
		pgp_pair_t port_e_dir;
		pgp_pair_t port_e_data;
		pgp_pair_t port_c_data;
		logic [31:0] prdata;
		logic pslverr;
	} pgp_state_s;

	typedef struct packed {
		logic en;
		pgp_pair_t dir;
		pgp_pair_t out;
	} pgp_alt_s;
endpackage

// file: hdl/pgp_sync.sv
`timescale 1ns/10ps
module pgp_sync import pgp_pkg::*; #(
	parameter int WIDTH = 2
) (
	input wire logic i_clk, // system clock
	input wire logic i_reset_n, // async reset
	input wire logic [WIDTH-1:0] i_async, // pin level
	output logic [WIDTH-1:0] o_sync // synchronised level
);
	logic [WIDTH-1:0] meta;

	// meta feeds only the second stage
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			meta <= '0;
			o_sync <= '0;
		end else begin
			meta <= i_async;
			o_sync <= meta;
		end
	end
endmodule // pgp_sync

// file: hdl/pgp_pin_mux.sv
`timescale 1ns/10ps
module pgp_pin_mux import pgp_pkg::*; (
	input wire pgp_alt_s i_alt, // alternate function request
	input wire pgp_pair_t i_dir, // stored direction, 1 = output
	input wire pgp_pair_t i_data, // stored data
	output pgp_pair_t o_pin, // pin drive value
	output pgp_pair_t o_oe_n // pin enable, low drives
);
	pgp_pair_t dir_eff;

	// the alternate function wins; stored bits are only bypassed, never altered
	always_comb begin
		dir_eff = i_alt.en ? i_alt.dir : i_dir;
		o_oe_n = ~dir_eff;
		o_pin = i_alt.en ? (i_alt.out & i_alt.dir) : (i_data & i_dir);
	end
endmodule // pgp_pin_mux

// file: hdl/pgp_top.sv
// Decided for this implementation: the APB slave port.
`timescale 1ns/10ps
// Overview of operation
// - port e read returns stored bit when output, synchronised pin when input
// - in output mode each port e data bit drives its pin
// - enabled oscillator overrides gpio on port e bit 1 and 0
// - eight-bit port a direction, 1 output, 0 input, resets to zero
// - enabled spi forces port a bits 3..0 direction, stored bits untouched
// - enabled oscillator owns port e pins, stored direction bits untouched
// - port c pin 1 carries die link interrupt when the link uses it
// - port c pin 0 carries die link clock when the link uses it
// - port c read returns stored bit when output, synchronised pin otherwise
// - direction and port c data registers read and write at any time
// - die link sets port c direction, stored direction bits untouched
module pgp_top import pgp_pkg::*; (
	input wire logic i_clk, // 10 MHz bus clock
	input wire logic i_reset_n, // async system reset
	input wire logic i_psel, // apb select
	input wire logic i_penable, // apb access phase
	input wire logic i_pwrite, // apb direction, 1 = write
	input wire logic [7:0] i_paddr, // apb byte address
	input wire logic [31:0] i_pwdata, // apb write data
	input wire logic [3:0] i_pstrb, // apb byte strobes
	output logic o_pready, // apb ready, always high
	output logic [31:0] o_prdata, // apb read data
	output logic o_pslverr, // apb error on unmapped address
	input wire logic i_spi_en, // spi owns port a bits 3..0
	input wire logic [3:0] i_spi_dir, // spi direction for those bits
	output logic [7:0] o_port_a_dir_eff, // port a direction in force
	input wire logic i_osc_en, // oscillator function enabled
	input wire logic i_crystal_out, // oscillator drive for port e pin 1
	output logic o_crystal_in, // port e pin 0 to the oscillator
	input wire logic [1:0] i_pe_pin, // port e pin levels
	output logic [1:0] o_pe_pin, // port e pin drive
	output logic [1:0] o_pe_oe_n, // port e enable, low drives
	input wire logic [1:0] i_port_c_dir, // stored port c direction
	input wire logic i_dl_en, // die link owns port c pins
	input wire logic i_die_link_clock, // die link clock to port c pin 0
	output logic o_die_link_interrupt, // port c pin 1 to the die link
	input wire logic [1:0] i_pc_pin, // port c pin levels
	output logic [1:0] o_pc_pin, // port c pin drive
	output logic [1:0] o_pc_oe_n // port c enable, low drives
);
	pgp_state_s state;
	pgp_state_s next_state;
	pgp_pair_t pe_sync;
	pgp_pair_t pc_sync;
	pgp_alt_s osc_alt;
	pgp_alt_s dl_alt;
	logic setup;
	logic wr_take;
	logic [5:0] idx;
	logic aligned;
	pgp_pair_t e_read_val;
	pgp_pair_t c_read_val;

	// per bit: stored data when driven, pin level when listening
	function automatic pgp_pair_t read_back(input pgp_pair_t dir, input pgp_pair_t data,
		input pgp_pair_t pin);
		read_back = (dir & data) | (~dir & pin);
	endfunction

	function automatic logic mapped(input logic [5:0] ix);
		mapped = (ix == `PGP_IDX_PORT_E_DATA) || (ix == `PGP_IDX_PORT_A_DIR) ||
			(ix == `PGP_IDX_PORT_E_DIR) || (ix == `PGP_IDX_PORT_C_DATA);
	endfunction

	pgp_sync #(.WIDTH(2)) u_pe_sync (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_async(i_pe_pin),
		.o_sync(pe_sync)
	);

	pgp_sync #(.WIDTH(2)) u_pc_sync (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_async(i_pc_pin),
		.o_sync(pc_sync)
	);

	always_comb begin
		// crystal output on pin 1, pin 0 left as input for the crystal
		osc_alt.en = i_osc_en;
		osc_alt.dir = 2'h2;
		osc_alt.out = {i_crystal_out, 1'b0};
		dl_alt.en = i_dl_en;
		dl_alt.dir = `PGP_DL_DIR;
		dl_alt.out = {1'b0, i_die_link_clock};
	end

	pgp_pin_mux u_pe_mux (
		.i_alt(osc_alt),
		.i_dir(state.port_e_dir),
		.i_data(state.port_e_data),
		.o_pin(o_pe_pin),
		.o_oe_n(o_pe_oe_n)
	);

	pgp_pin_mux u_pc_mux (
		.i_alt(dl_alt),
		.i_dir(i_port_c_dir),
		.i_data(state.port_c_data),
		.o_pin(o_pc_pin),
		.o_oe_n(o_pc_oe_n)
	);

	// the crystal is analog; passing it raw avoids sampling a clock with itself
	assign o_crystal_in = i_pe_pin[0];
	assign o_die_link_interrupt = pc_sync[1];

	// spi override never writes the stored bits
	assign o_port_a_dir_eff = i_spi_en ? {state.port_a_dir[7:4], i_spi_dir} :
		state.port_a_dir;

	assign idx = i_paddr[7:2];
	assign aligned = (i_paddr[1:0] == 2'h0);
	assign setup = i_psel && !i_penable;
	assign wr_take = i_psel && i_penable && i_pwrite && i_pstrb[0] && aligned;
	assign e_read_val = read_back(state.port_e_dir, state.port_e_data, pe_sync);
	assign c_read_val = read_back(i_port_c_dir, state.port_c_data, pc_sync);

	always_comb begin
		next_state = state;
		if (setup) begin
			// read data is latched in setup so the access phase needs no wait
			next_state.pslverr = !(aligned && mapped(idx));
			next_state.prdata = 32'h0000_0000;
			// misaligned reads return zero like unmapped ones
			if (!i_pwrite && aligned) begin
				case (idx)
					`PGP_IDX_PORT_E_DATA: next_state.prdata[1:0] = e_read_val;
					`PGP_IDX_PORT_A_DIR: next_state.prdata[7:0] = state.port_a_dir;
					`PGP_IDX_PORT_E_DIR: next_state.prdata[1:0] = state.port_e_dir;
					`PGP_IDX_PORT_C_DATA: next_state.prdata[1:0] = c_read_val;
					default: next_state.prdata = 32'h0000_0000;
				endcase
			end
		end
		// writes ignore every mode input; upper bits are simply not stored
		if (wr_take) begin
			case (idx)
				`PGP_IDX_PORT_E_DATA: next_state.port_e_data = i_pwdata[1:0];
				`PGP_IDX_PORT_A_DIR: next_state.port_a_dir = i_pwdata[7:0];
				`PGP_IDX_PORT_E_DIR: next_state.port_e_dir = i_pwdata[1:0];
				`PGP_IDX_PORT_C_DATA: next_state.port_c_data = i_pwdata[1:0];
				default: next_state.port_a_dir = state.port_a_dir;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state.port_a_dir <= `PGP_RST_PORT_A_DIR;
			state.port_e_dir <= `PGP_RST_PORT_E_DIR;
			state.port_e_data <= `PGP_RST_PORT_E_DATA;
			state.port_c_data <= `PGP_RST_PORT_C_DATA;
			state.prdata <= 32'h0000_0000;
			state.pslverr <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	assign o_pready = 1'b1;
	assign o_prdata = state.prdata;
	assign o_pslverr = state.pslverr;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_reset_n);

	logic e_rd_setup;
	logic c_rd_setup;
	assign e_rd_setup = setup && !i_pwrite && aligned && (idx == `PGP_IDX_PORT_E_DATA);
	assign c_rd_setup = setup && !i_pwrite && aligned && (idx == `PGP_IDX_PORT_C_DATA);

	// per-register write strobes, shared by the hold checks below
	logic wr_a_dir;
	logic wr_e_dir;
	logic wr_e_data;
	logic wr_c_data;
	logic bad_access;
	assign wr_a_dir = wr_take && (idx == `PGP_IDX_PORT_A_DIR);
	assign wr_e_dir = wr_take && (idx == `PGP_IDX_PORT_E_DIR);
	assign wr_e_data = wr_take && (idx == `PGP_IDX_PORT_E_DATA);
	assign wr_c_data = wr_take && (idx == `PGP_IDX_PORT_C_DATA);
	assign bad_access = !(aligned && mapped(idx));

	a_pe_read_back: assert property (
		e_rd_setup |=> (o_prdata == {30'h0, $past(e_read_val)}) &&
			($past(state.port_e_dir[1]) -> (o_prdata[1] == $past(state.port_e_data[1]))))
		else $error("port e read value wrong");

	a_pe_gpio_drive: assert property (
		!i_osc_en |-> (o_pe_oe_n == ~state.port_e_dir) &&
			((o_pe_pin & state.port_e_dir) == (state.port_e_data & state.port_e_dir)))
		else $error("port e gpio drive wrong");

	a_osc_pin_take: assert property (
		i_osc_en |-> (o_pe_pin[1] == i_crystal_out) && !o_pe_oe_n[1] && o_pe_oe_n[0])
		else $error("oscillator does not own port e");

	a_pa_dir_write: assert property (
		wr_a_dir |=> state.port_a_dir == $past(i_pwdata[7:0]))
		else $error("port a direction write lost");

	a_spi_force_dir: assert property (
		(i_spi_en && !wr_take) |-> (o_port_a_dir_eff == {state.port_a_dir[7:4], i_spi_dir})
			##1 $stable(state.port_a_dir))
		else $error("spi override wrong or stored bits moved");

	a_osc_dir_kept: assert property (
		(i_osc_en && !wr_take) |=> $stable(state.port_e_dir))
		else $error("oscillator altered stored direction");

	a_dl_int_path: assert property (
		(i_dl_en ##2 i_dl_en) |-> o_die_link_interrupt == $past(i_pc_pin[1], 2))
		else $error("die link interrupt not passed");

	a_dl_clk_drive: assert property (
		i_dl_en |-> (o_pc_pin[0] == i_die_link_clock) && !o_pc_oe_n[0])
		else $error("die link clock not driven");

	a_pc_read_back: assert property (
		c_rd_setup |=> o_prdata[1:0] == $past(c_read_val) && o_prdata[31:2] == 30'h0)
		else $error("port c read value wrong");

	a_pc_write_any: assert property (
		(wr_take && idx == `PGP_IDX_PORT_C_DATA) |=> state.port_c_data == $past(i_pwdata[1:0]))
		else $error("port c write refused");

	a_dl_dir_own: assert property (
		i_dl_en |-> (o_pc_oe_n == ~`PGP_DL_DIR) && (o_pc_pin[1] == 1'b0))
		else $error("die link direction not applied");

	a_upper_zero: assert property (
		(setup && !i_pwrite && aligned && idx == `PGP_IDX_PORT_E_DIR) |=>
			o_prdata == {30'h0, state.port_e_dir})
		else $error("upper bits not zero");

	a_pready_high: assert property (
		o_pready)
		else $error("apb ready dropped");

	a_err_bad_addr: assert property (
		(setup && bad_access) |=> o_pslverr && (o_prdata == 32'h0000_0000))
		else $error("bad address not refused");

	a_err_good_addr: assert property (
		(setup && !bad_access) |=> !o_pslverr)
		else $error("mapped address refused");

	a_rdata_hold: assert property (
		!setup |=> $stable(o_prdata) && $stable(o_pslverr))
		else $error("read data moved outside setup");

	a_bad_write_kept: assert property (
		(i_psel && i_penable && i_pwrite && bad_access) |=>
			$stable(state.port_a_dir) && $stable(state.port_e_dir) &&
			$stable(state.port_e_data) && $stable(state.port_c_data))
		else $error("refused write changed a register");

	a_strb_write_kept: assert property (
		(i_psel && i_penable && i_pwrite && !i_pstrb[0]) |=>
			$stable(state.port_a_dir) && $stable(state.port_e_dir) &&
			$stable(state.port_e_data) && $stable(state.port_c_data))
		else $error("write without lane 0 changed a register");

	// stored bits move only on their own write; overrides never touch them
	a_pa_dir_hold: assert property (
		!wr_a_dir |=> $stable(state.port_a_dir))
		else $error("port a direction moved without a write");

	a_pe_dir_hold: assert property (
		!wr_e_dir |=> $stable(state.port_e_dir))
		else $error("port e direction moved without a write");

	a_pe_data_hold: assert property (
		!wr_e_data |=> $stable(state.port_e_data))
		else $error("port e data moved without a write");

	a_pc_data_hold: assert property (
		!wr_c_data |=> $stable(state.port_c_data))
		else $error("port c data moved without a write");

	a_pe_data_write: assert property (
		wr_e_data |=> state.port_e_data == $past(i_pwdata[1:0]))
		else $error("port e data write lost");

	a_pe_dir_write: assert property (
		wr_e_dir |=> state.port_e_dir == $past(i_pwdata[1:0]))
		else $error("port e direction write lost");

	a_pe_stored_read: assert property (
		e_rd_setup |=>
			((o_prdata[1:0] ^ $past(state.port_e_data)) & $past(state.port_e_dir)) == 2'h0)
		else $error("port e output bit not read from register");

	a_pe_pin_read: assert property (
		(e_rd_setup && $past(i_reset_n, 1) && $past(i_reset_n, 2)) |=>
			((o_prdata[1:0] ^ $past(i_pe_pin, 3)) & ~$past(state.port_e_dir)) == 2'h0)
		else $error("port e input bit not read from pin");

	a_pc_stored_read: assert property (
		c_rd_setup |=>
			((o_prdata[1:0] ^ $past(state.port_c_data)) & $past(i_port_c_dir)) == 2'h0)
		else $error("port c output bit not read from register");

	a_pc_pin_read: assert property (
		(c_rd_setup && $past(i_reset_n, 1) && $past(i_reset_n, 2)) |=>
			((o_prdata[1:0] ^ $past(i_pc_pin, 3)) & ~$past(i_port_c_dir)) == 2'h0)
		else $error("port c input bit not read from pin");

	a_pe_idle_zero: assert property (
		!i_osc_en |-> (o_pe_pin & ~state.port_e_dir) == 2'h0)
		else $error("port e drives a listening pin");

	a_osc_in_zero: assert property (
		i_osc_en |-> !o_pe_pin[0] && (o_crystal_in == i_pe_pin[0]))
		else $error("crystal input pin not left to the oscillator");

	a_pc_gpio_drive: assert property (
		!i_dl_en |-> (o_pc_oe_n == ~i_port_c_dir) &&
			(o_pc_pin == (state.port_c_data & i_port_c_dir)))
		else $error("port c gpio drive wrong");

	a_pa_eff_gpio: assert property (
		!i_spi_en |-> o_port_a_dir_eff == state.port_a_dir)
		else $error("port a direction in force differs from register");

	a_spi_upper_kept: assert property (
		i_spi_en |-> o_port_a_dir_eff[7:4] == state.port_a_dir[7:4])
		else $error("spi override reached port a bits 7..4");

	a_pe_upper_zero: assert property (
		e_rd_setup |=> o_prdata[31:2] == 30'h0)
		else $error("port e data upper bits not zero");

	a_pa_read_back: assert property (
		(setup && !i_pwrite && !bad_access && idx == `PGP_IDX_PORT_A_DIR) |=>
			o_prdata == {24'h0, $past(state.port_a_dir)})
		else $error("port a direction read wrong");

	a_int_pin_listen: assert property (
		i_dl_en |-> o_pc_oe_n[1])
		else $error("die link interrupt pin driven");
endmodule // pgp_top

// file: dv/pgp_top_tb.sv
`timescale 1ns/10ps
`include "pgp_consts.svh"
module pgp_top_tb import pgp_pkg::*; ;
	localparam logic [7:0] A_E_DATA = {`PGP_IDX_PORT_E_DATA, 2'b00};
	localparam logic [7:0] A_A_DIR = {`PGP_IDX_PORT_A_DIR, 2'b00};
	localparam logic [7:0] A_E_DIR = {`PGP_IDX_PORT_E_DIR, 2'b00};
	localparam logic [7:0] A_C_DATA = {`PGP_IDX_PORT_C_DATA, 2'b00};
	logic clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [3:0] pstrb = 4'hf, spi_dir = 4'h0;
	logic pready, pslverr, spi_en = 1'b0, osc_en = 1'b0, xout = 1'b0, xin;
	logic dl_en = 1'b0, dl_clk = 1'b0, dl_int;
	logic [7:0] a_eff;
	logic [1:0] pe_pin = 2'b01, pc_pin = 2'b10, pc_dir = 2'b00, dv;
	logic [1:0] pe_o, pe_oe_n, pc_o, pc_oe_n;
	int n_errors = 0, checks = 0;

	always #50 clk = ~clk;

	pgp_top dut (.i_clk(clk), .i_reset_n(reset_n), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
		.o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr), .i_spi_en(spi_en),
		.i_spi_dir(spi_dir), .o_port_a_dir_eff(a_eff), .i_osc_en(osc_en),
		.i_crystal_out(xout), .o_crystal_in(xin), .i_pe_pin(pe_pin), .o_pe_pin(pe_o),
		.o_pe_oe_n(pe_oe_n), .i_port_c_dir(pc_dir), .i_dl_en(dl_en),
		.i_die_link_clock(dl_clk), .o_die_link_interrupt(dl_int), .i_pc_pin(pc_pin),
		.o_pc_pin(pc_o), .o_pc_oe_n(pc_oe_n));

	task automatic finish_test();
		if (n_errors == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one apb transfer; request held until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] rd, output logic err);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// only the watchdog ends a wait that never sees pready
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic eerr);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, exp);
		chk({31'h0, e}, {31'h0, eerr});
	endtask

	initial begin
		#2000000;
		n_errors++;
		finish_test();
	end

	initial begin
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		rd(A_A_DIR, 32'h0, 1'b0);
		rd(A_E_DIR, 32'h0, 1'b0);
		rd(A_C_DATA, 32'h2, 1'b0);
		wr(A_A_DIR, 32'hffffffa5);
		rd(A_A_DIR, 32'ha5, 1'b0);
		chk(a_eff, 32'ha5);
		@(posedge clk);
		pstrb <= 4'h0;
		wr(A_A_DIR, 32'h0);
		pstrb <= 4'hf;
		rd(A_A_DIR, 32'ha5, 1'b0);
		spi_en <= 1'b1;
		spi_dir <= 4'h3;
		@(negedge clk);
		chk(a_eff, 32'ha3);
		rd(A_A_DIR, 32'ha5, 1'b0);
		spi_en <= 1'b0;
		rd(8'h20, 32'h0, 1'b1);
		rd(8'h09, 32'h0, 1'b1);
		wr(8'h0b, 32'h0);
		rd(A_A_DIR, 32'ha5, 1'b0);
		wr(A_E_DATA, 32'hfe);
		for (int i = 0; i < 4; i++) begin
			dv = 2'(i);
			wr(A_E_DIR, {30'h3fffffff, dv});
			rd(A_E_DIR, {30'h0, dv}, 1'b0);
			rd(A_E_DATA, {30'h0, (2'b10 & dv) | (2'b01 & ~dv)}, 1'b0);
			chk({30'h0, pe_oe_n}, {30'h0, ~dv});
			chk(pe_o & ~pe_oe_n, 2'b10 & dv);
		end
		osc_en <= 1'b1;
		xout <= 1'b1;
		@(negedge clk);
		chk(pe_oe_n, 2'b01);
		chk({pe_o[1], xin}, 2'b11);
		rd(A_E_DIR, 32'h3, 1'b0);
		osc_en <= 1'b0;
		@(negedge clk);
		chk(pe_oe_n, 2'b00);
		wr(A_C_DATA, 32'hfd);
		for (int i = 0; i < 4; i++) begin
			dv = 2'(i);
			@(posedge clk);
			pc_dir <= dv;
			rd(A_C_DATA, {30'h0, (2'b01 & dv) | (2'b10 & ~dv)}, 1'b0);
			chk(pc_o & ~pc_oe_n, 2'b01 & dv);
		end
		dl_en <= 1'b1;
		dl_clk <= 1'b1;
		@(negedge clk);
		chk(pc_oe_n, 2'b10);
		chk(pc_o[0], 1'b1);
		repeat (3) @(posedge clk);
		chk(dl_int, 1'b1);
		pc_pin <= 2'b00;
		dl_clk <= 1'b0;
		repeat (3) @(posedge clk);
		chk(dl_int, 1'b0);
		chk(pc_o[0], 1'b0);
		// second reset in mid-run: port a and port e direction registers must read back zero
		reset_n <= 1'b0;
		@(posedge clk);
		reset_n <= 1'b1;
		rd(A_A_DIR, 32'h0, 1'b0);
		rd(A_E_DIR, 32'h0, 1'b0);
		rd(A_E_DATA, 32'h1, 1'b0);
		finish_test();
	end
endmodule // pgp_top_tb
